// [include/pct_params.svh]
// Purpose: constants of the preset counter and tachometer
// Assumes: 100 MHz clock, six-digit decimal count range
// Notes: the gate length of the rate meter is a top parameter
// Operation
// RQ1: single-count modes: inc, dec, up/down forms
// RQ2: dual/twin: input a to value a, b to b
// RQ3: reset one clears value and outputs; in batch the code keeps output a
// RQ4: reset one blocks counting while asserted
// RQ5: reset one lights reset indicator
// RQ6: reset loads zero or set value when decrementing
// RQ7: dual/twin: reset one zeroes value a
// RQ8: dual/twin: reset one lights reset indicator
// RQ9: preset configurations ignore reset two
// RQ10: total: reset two holds total at zero
// RQ11: batch: reset two zeroes batch, output a
// RQ12: dual: reset two zeroes and blocks b
// RQ13: twin: reset two resets value b
// RQ14: reset two never lights reset indicator
// RQ15: outputs switch when set value reached
// RQ16: rate meter reads b unless single-input
// RQ17: rate meter resets act as hold inputs
// RQ18: hold key freezes measurement and outputs
// RQ19: hold indicator lit while value held
// RQ20: source keeps reset pulses long enough
// RQ21: source keeps hold off 20 ms between pulses
// RQ22: inputs synchronised, reset beats count
`ifndef PCT_PARAMS_SVH
`define PCT_PARAMS_SVH
`define PCT_W 20
`define PCT_MAX 20'hf423f
`define PCT_ZERO 20'h00000
`define PCT_NSYNC 5
`define PCT_GATE_MS 1000
`define PCT_CLK_KHZ 100000
`define PCT_GATE_CYC (`PCT_GATE_MS * `PCT_CLK_KHZ)
`endif

// [include/pct_pkg.sv]
// Purpose: types of the preset counter and tachometer
// Assumes: nothing
// Notes: setup travels as one packed struct
package pct_pkg;
    typedef enum logic [2:0] {
        PCT_CFG_PRESET1 = 3'h0,
        PCT_CFG_PRESET2 = 3'h1,
        PCT_CFG_TOTAL = 3'h2,
        PCT_CFG_BATCH = 3'h3,
        PCT_CFG_DUAL = 3'h4,
        PCT_CFG_TWIN = 3'h5,
        PCT_CFG_TACHO = 3'h6
    } pct_cfg_t;
    typedef enum logic [2:0] {
        PCT_CM_INC = 3'h0,
        PCT_CM_DEC = 3'h1,
        PCT_CM_CMD = 3'h2,
        PCT_CM_IND = 3'h3,
        PCT_CM_QUAD = 3'h4
    } pct_cmode_t;
    typedef enum logic [1:0] {
        PCT_TM_SINGLE = 2'h0,
        PCT_TM_INDEP = 2'h1,
        PCT_TM_OTHER = 2'h2
    } pct_tmode_t;
    typedef struct packed {
        pct_cfg_t cfg;
        pct_cmode_t cmode;
        pct_tmode_t tmode;
        logic latch;
        logic [19:0] set1;
        logic [19:0] set2;
    } pct_setup_t;
    typedef struct packed {
        logic [19:0] value_a;
        logic [19:0] value_b;
        logic [19:0] total;
        logic [19:0] batch;
    } pct_values_t;
endpackage : pct_pkg

// [hdl/pct_core.sv]
// Purpose: count, reset, hold and compare logic of the counter
// Assumes: all pins asynchronous; setup static or quasi-static
// Notes: values wrap within six decimal digits
`timescale 1ns/1ns
`include "pct_params.svh"
module pct_core
    import pct_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = `PCT_GATE_CYC
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire pct_setup_t setup_in,
    input wire logic count_input_a_in,
    input wire logic count_input_b_in,
    input wire logic reset1_in,
    input wire logic reset2_in,
    input wire logic hold_key_in,
    output logic compare_output_a_out,
    output logic compare_output_b_out,
    output logic reset_ind_out,
    output logic hold_ind_out,
    output pct_values_t values_out
);
    logic [`PCT_NSYNC-1:0] pin_w, s1_q, s2_q, p_q;
    logic [`PCT_NSYNC-1:0] s1_d, s2_d, p_d, rise;
    pct_values_t v_q, v_d;
    logic [`PCT_W-1:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;
    logic [31:0] gate_q, gate_d;
    logic oa_q, oa_d, ob_q, ob_d, ri_q, ri_d, hi_q, hi_d;
    logic a_rise, b_rise, r1, r2, r2_rise, key, up, dn, dec;
    logic tacho, twoch, hold_a, hold_b, gate_end;
    logic hit_a, hit_b, clr_a, clr_b;

    function automatic logic [`PCT_W-1:0] inc(input logic [`PCT_W-1:0] v);
        return (v == `PCT_MAX) ? `PCT_ZERO : `PCT_W'(v + 1'b1);
    endfunction : inc

    function automatic logic [`PCT_W-1:0] decr(input logic [`PCT_W-1:0] v);
        return (v == `PCT_ZERO) ? `PCT_MAX : `PCT_W'(v - 1'b1);
    endfunction : decr

    function automatic logic reached(input logic [`PCT_W-1:0] v,
                                     input logic [`PCT_W-1:0] s,
                                     input logic down);
        return down ? (v == `PCT_ZERO) : (v == s);
    endfunction : reached

    assign pin_w = {hold_key_in, reset2_in, reset1_in,
                    count_input_b_in, count_input_a_in};

    // two-stage synchronisers, edge detect on second stage
    genvar gi;
    generate
        for (gi = 0; gi < `PCT_NSYNC; gi++) begin : g_sync
            always_comb begin
                s1_d[gi] = pin_w[gi]; // see RQ22
                s2_d[gi] = s1_q[gi];
                p_d[gi] = s2_q[gi];
                rise[gi] = s2_q[gi] & ~p_q[gi];
            end
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    p_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= s1_d[gi];
                    s2_q[gi] <= s2_d[gi];
                    p_q[gi] <= p_d[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        a_rise = rise[0];
        b_rise = rise[1];
        r1 = s2_q[2];
        r2 = s2_q[3];
        r2_rise = rise[3];
        key = s2_q[4];
        tacho = (setup_in.cfg == PCT_CFG_TACHO);
        twoch = (setup_in.cfg == PCT_CFG_DUAL) |
                (setup_in.cfg == PCT_CFG_TWIN);
        dec = (setup_in.cmode == PCT_CM_DEC);
        v_d = v_q;
        cnt_a_d = cnt_a_q;
        cnt_b_d = cnt_b_q;
        gate_d = gate_q;
        oa_d = oa_q;
        ob_d = ob_q;
        clr_a = 1'b0;
        clr_b = 1'b0;
        hit_a = 1'b0;
        hit_b = 1'b0;
        up = 1'b0;
        dn = 1'b0;
        hold_a = 1'b0;
        hold_b = 1'b0;
        gate_end = 1'b0;
        // count direction decode
        unique case (setup_in.cmode)
            PCT_CM_INC: up = a_rise; // see RQ1
            PCT_CM_DEC: dn = a_rise;
            PCT_CM_CMD: begin
                up = a_rise & ~s2_q[1];
                dn = a_rise & s2_q[1];
            end
            PCT_CM_IND: begin
                up = a_rise & ~b_rise;
                dn = b_rise & ~a_rise;
            end
            PCT_CM_QUAD: begin
                up = a_rise & ~s2_q[1];
                dn = a_rise & s2_q[1];
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
        if (tacho) begin
            hold_a = r1 | key; // see RQ17 see RQ18
            hold_b = ((setup_in.tmode == PCT_TM_INDEP) ? r2 : r1) | key;
            gate_end = (gate_q == GATE_CYCLES - 1);
            gate_d = gate_end ? 32'h0 : gate_q + 32'h1;
            // a rise on the last gate edge opens the next window
            cnt_a_d = a_rise ? inc(gate_end ? `PCT_ZERO : cnt_a_q) :
                      (gate_end ? `PCT_ZERO : cnt_a_q);
            if (setup_in.tmode != PCT_TM_SINGLE) begin // see RQ16
                cnt_b_d = b_rise ? inc(gate_end ? `PCT_ZERO : cnt_b_q) :
                          (gate_end ? `PCT_ZERO : cnt_b_q);
            end else begin
                cnt_b_d = `PCT_ZERO;
            end
            if (gate_end && !hold_a) begin
                v_d.value_a = cnt_a_q;
            end
            if (gate_end && !hold_b) begin
                v_d.value_b = cnt_b_q;
            end
            hit_a = (v_d.value_a >= setup_in.set1); // see RQ15
            hit_b = (setup_in.tmode == PCT_TM_INDEP) ?
                    (v_d.value_b >= setup_in.set2) :
                    (v_d.value_a >= setup_in.set2);
            if (!hold_a) begin
                oa_d = setup_in.latch ? (oa_q | hit_a) : hit_a;
            end
            if (!hold_b) begin
                ob_d = setup_in.latch ? (ob_q | hit_b) : hit_b;
            end
        end else begin
            if (twoch) begin
                if (r1) begin // see RQ7 see RQ22
                    v_d.value_a = `PCT_ZERO;
                    clr_a = 1'b1;
                end else if (a_rise) begin
                    v_d.value_a = inc(v_q.value_a); // see RQ2
                end
                if ((setup_in.cfg == PCT_CFG_DUAL) && r2) begin // see RQ12
                    v_d.value_b = `PCT_ZERO;
                    clr_b = 1'b1;
                end else if ((setup_in.cfg == PCT_CFG_TWIN) && r2_rise) begin
                    v_d.value_b = `PCT_ZERO; // see RQ13
                    clr_b = 1'b1;
                end else if (b_rise) begin
                    v_d.value_b = inc(v_q.value_b);
                end
                hit_a = reached(v_d.value_a, setup_in.set1, 1'b0);
                hit_b = reached(v_d.value_b, setup_in.set2, 1'b0);
            end else begin
                if (r1) begin // see RQ3 see RQ4
                    if (dec) begin // see RQ6
                        v_d.value_a = (setup_in.cfg == PCT_CFG_PRESET2) ?
                                      setup_in.set2 : setup_in.set1;
                    end else begin
                        v_d.value_a = `PCT_ZERO;
                    end
                    clr_b = 1'b1;
                    clr_a = (setup_in.cfg != PCT_CFG_BATCH);
                end else if (up) begin
                    v_d.value_a = inc(v_q.value_a);
                end else if (dn) begin
                    v_d.value_a = decr(v_q.value_a);
                end
                if (!r1 && (up || dn)) begin
                    v_d.total = inc(v_q.total);
                end
                // see RQ9: reset two reaches only total and batch
                if ((setup_in.cfg == PCT_CFG_TOTAL) && r2) begin
                    v_d.total = `PCT_ZERO; // see RQ10
                end
                hit_b = reached(v_d.value_a,
                                (setup_in.cfg == PCT_CFG_BATCH ||
                                 setup_in.cfg == PCT_CFG_PRESET1) ?
                                setup_in.set1 : setup_in.set2, dec);
                hit_a = reached(v_d.value_a, setup_in.set1, dec);
                if (setup_in.cfg == PCT_CFG_PRESET1) begin
                    hit_a = 1'b0;
                end
                if (setup_in.cfg == PCT_CFG_BATCH) begin
                    if (hit_b && (v_d.value_a != v_q.value_a)) begin
                        v_d.batch = inc(v_q.batch);
                    end
                    if (r2) begin // see RQ11
                        v_d.batch = `PCT_ZERO;
                        clr_a = 1'b1;
                    end
                    hit_a = (v_d.batch >= setup_in.set2) &&
                            (v_d.batch != `PCT_ZERO);
                end
            end
            oa_d = clr_a ? 1'b0 :
                   (setup_in.latch ? (oa_q | hit_a) : hit_a); // see RQ15
            ob_d = clr_b ? 1'b0 :
                   (setup_in.latch ? (ob_q | hit_b) : hit_b);
        end
        ri_d = ~tacho & r1; // see RQ5 see RQ8 see RQ14
        hi_d = tacho & (hold_a | hold_b); // see RQ19
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            v_q <= '0;
            cnt_a_q <= `PCT_ZERO;
            cnt_b_q <= `PCT_ZERO;
            gate_q <= 32'h0;
            oa_q <= 1'b0;
            ob_q <= 1'b0;
            ri_q <= 1'b0;
            hi_q <= 1'b0;
        end else begin
            v_q <= v_d;
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
            gate_q <= gate_d;
            oa_q <= oa_d;
            ob_q <= ob_d;
            ri_q <= ri_d;
            hi_q <= hi_d;
        end
    end

    assign compare_output_a_out = oa_q;
    assign compare_output_b_out = ob_q;
    assign reset_ind_out = ri_q;
    assign hold_ind_out = hi_q;
    assign values_out = v_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    a_reset_ind_pin: assert property ( // see RQ5
        ##3 ($past(reset1_in, 3) && $past(reset1_in, 4) &&
             setup_in.cfg != PCT_CFG_TACHO && $stable(setup_in.cfg))
        |-> reset_ind_out)
        else $error("reset indicator not lit during reset one");
    a_reset2_dark: assert property ( // see RQ14
        (!r1 && $past(!r1)) |=> !reset_ind_out)
        else $error("reset indicator lit without reset one");
    a_r1_blocks: assert property ( // see RQ4
        (r1 && $past(r1) && !tacho && $stable(setup_in)) |=>
        $stable(v_q.value_a))
        else $error("value changed while reset one held");
    a_r1_clears: assert property ( // see RQ3
        (r1 && setup_in.cfg == PCT_CFG_PRESET2) |=> !compare_output_b_out)
        else $error("output not cleared by reset one");
    a_total_zero: assert property ( // see RQ10
        (r2 && setup_in.cfg == PCT_CFG_TOTAL) |=> v_q.total == `PCT_ZERO)
        else $error("total not held at zero");
    a_batch_zero: assert property ( // see RQ11
        (r2 && setup_in.cfg == PCT_CFG_BATCH) |=>
        (v_q.batch == `PCT_ZERO && !compare_output_a_out))
        else $error("batch or its output not cleared");
    a_dual_b_zero: assert property ( // see RQ12
        (r2 && setup_in.cfg == PCT_CFG_DUAL) |=> v_q.value_b == `PCT_ZERO)
        else $error("dual value b not held at zero");
    a_twin_a_zero: assert property ( // see RQ7
        (r1 && twoch) |=> (v_q.value_a == `PCT_ZERO && !compare_output_a_out))
        else $error("value a not cleared by reset one");
    a_tacho_freeze: assert property ( // see RQ18
        (tacho && key && $stable(setup_in)) |=>
        ($stable(v_q.value_a) && $stable(compare_output_a_out)))
        else $error("measurement moved while held");
    a_hold_ind: assert property ( // see RQ19
        (tacho && key) |=> hold_ind_out)
        else $error("hold indicator dark while held");
    a_dec_load: assert property ( // see RQ6
        (r1 && dec && setup_in.cfg == PCT_CFG_PRESET2) |=>
        v_q.value_a == $past(setup_in.set2))
        else $error("decrement reset value wrong");
    a_sync_lat: assert property ( // see RQ22
        (setup_in.cfg == PCT_CFG_PRESET1 && $stable(setup_in.cfg) &&
         $rose(reset1_in)) |-> ##2 r1)
        else $error("reset one not seen after two stages");
    a_batch_r1_keep: assert property ( // see RQ3
        (r1 && !r2 && setup_in.cfg == PCT_CFG_BATCH && setup_in.latch &&
         compare_output_a_out && $stable(setup_in)) |=> compare_output_a_out)
        else $error("reset one cleared batch output");
    a_twin_b_clear: assert property ( // see RQ13
        (r2_rise && setup_in.cfg == PCT_CFG_TWIN) |=> v_q.value_b == `PCT_ZERO)
        else $error("twin value b not reset");
    a_tacho_rind: assert property ( // see RQ5
        tacho |=> !reset_ind_out)
        else $error("reset indicator lit in rate meter use");
endmodule : pct_core

// [bench/pct_sensor_model.sv]
// Purpose: pulse sensor at a count pin of the counter
// Assumes: one fire strobe per pulse, strobes spaced >= 7 clocks
// Notes: each pulse is 3 clocks high, then at least 3 clocks low
`timescale 1ns/1ns
module pct_sensor_model (
    input wire logic clock_in,
    input wire logic fire_in,
    output logic pin_out
);
    logic [2:0] cnt_q = 3'h0;
    always_ff @(posedge clock_in) begin
        if (fire_in && cnt_q == 3'h0) begin
            cnt_q <= 3'h6;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // pin high only in upper half of the count
    assign pin_out = (cnt_q > 3'h3);
endmodule : pct_sensor_model

// [bench/tb_top.sv]
// Purpose: directed tests of counting, resets and hold
// Assumes: fixed pin-to-output latency of 3 clocks
// Notes: setup changed only under srst_in
`timescale 1ns/1ns
module tb_top;
    import pct_pkg::*;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    pct_setup_t setup_in = '0;
    logic fire_a = 1'b0;
    logic fire_b = 1'b0;
    logic reset1_in = 1'b0;
    logic reset2_in = 1'b0;
    logic hold_key_in = 1'b0;
    logic pin_a, pin_b, out_a, out_b, rst_ind, hold_ind;
    pct_values_t vals;
    int n_mismatch = 0;
    int checked = 0;
    pct_sensor_model i_src_a (.clock_in(clock_in), .fire_in(fire_a),
        .pin_out(pin_a));
    pct_sensor_model i_src_b (.clock_in(clock_in), .fire_in(fire_b),
        .pin_out(pin_b));
    pct_core #(.GATE_CYCLES(20)) i_dut (.clock_in(clock_in),
        .srst_in(srst_in), .setup_in(setup_in),
        .count_input_a_in(pin_a), .count_input_b_in(pin_b),
        .reset1_in(reset1_in), .reset2_in(reset2_in),
        .hold_key_in(hold_key_in), .compare_output_a_out(out_a),
        .compare_output_b_out(out_b), .reset_ind_out(rst_ind),
        .hold_ind_out(hold_ind), .values_out(vals));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wait_clk
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic start(input pct_cfg_t c, input pct_cmode_t m,
                         input logic [19:0] s1, input logic [19:0] s2);
        @(posedge clock_in);
        srst_in <= 1'b1;
        setup_in <= '{cfg: c, cmode: m, tmode: PCT_TM_SINGLE, latch: 1'b1,
                      set1: s1, set2: s2};
        wait_clk(3);
        srst_in <= 1'b0;
        wait_clk(2);
    endtask : start
    task automatic pulse(input logic on_b, input int n);
        repeat (n) begin
            @(posedge clock_in);
            if (on_b) fire_b <= 1'b1;
            else fire_a <= 1'b1;
            @(posedge clock_in);
            fire_a <= 1'b0;
            fire_b <= 1'b0;
            wait_clk(8);
        end
    endtask : pulse
    // reset pins held well past the sync delay, off-time likewise
    task automatic set_rst(input logic two, input logic lvl);
        @(posedge clock_in);
        if (two) reset2_in <= lvl;
        else reset1_in <= lvl;
        wait_clk(6);
    endtask : set_rst
    initial begin
        wait_clk(12);
        srst_in <= 1'b0;
        start(PCT_CFG_PRESET1, PCT_CM_INC, 20'h00003, 20'h00000);
        pulse(1'b0, 3);
        check(vals.value_a, 20'h00003);
        check(out_b, 1'b1);
        set_rst(1'b1, 1'b1);
        check(vals.value_a, 20'h00003);
        check(rst_ind, 1'b0);
        set_rst(1'b1, 1'b0);
        set_rst(1'b0, 1'b1);
        check(vals.value_a, 20'h00000);
        check(out_b, 1'b0);
        check(rst_ind, 1'b1);
        pulse(1'b0, 2);
        check(vals.value_a, 20'h00000);
        set_rst(1'b0, 1'b0);
        check(rst_ind, 1'b0);
        $display("test preset done");
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? PCT_CFG_PRESET1 : PCT_CFG_PRESET2, PCT_CM_DEC,
                  20'h00005, 20'h00007);
            set_rst(1'b0, 1'b1);
            set_rst(1'b0, 1'b0);
            check(vals.value_a, k == 0 ? 20'h00005 : 20'h00007);
            pulse(1'b0, 1);
            check(vals.value_a, k == 0 ? 20'h00004 : 20'h00006);
        end
        $display("test decrement done");
        start(PCT_CFG_PRESET2, PCT_CM_IND, 20'h00002, 20'h00003);
        pulse(1'b0, 2);
        pulse(1'b1, 1);
        check(vals.value_a, 20'h00001);
        check(out_a, 1'b1);
        check(out_b, 1'b0);
        set_rst(1'b0, 1'b1);
        check(out_a, 1'b0);
        set_rst(1'b0, 1'b0);
        $display("test up down done");
        start(PCT_CFG_TOTAL, PCT_CM_INC, 20'h00009, 20'h00009);
        pulse(1'b0, 2);
        check(vals.total, 20'h00002);
        set_rst(1'b1, 1'b1);
        pulse(1'b0, 1);
        check(vals.total, 20'h00000);
        check(vals.value_a, 20'h00003);
        set_rst(1'b1, 1'b0);
        $display("test total done");
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? PCT_CFG_DUAL : PCT_CFG_TWIN, PCT_CM_INC,
                  20'h00002, 20'h00002);
            pulse(1'b0, 1);
            pulse(1'b1, 2);
            check(vals.value_a, 20'h00001);
            check(vals.value_b, 20'h00002);
            check(out_b, 1'b1);
            set_rst(1'b1, 1'b1);
            check(vals.value_b, 20'h00000);
            check(rst_ind, 1'b0);
            if (k == 0) begin
                pulse(1'b1, 1);
                check(vals.value_b, 20'h00000);
            end
            set_rst(1'b1, 1'b0);
            set_rst(1'b0, 1'b1);
            check(vals.value_a, 20'h00000);
            check(rst_ind, 1'b1);
            pulse(1'b0, 1);
            check(vals.value_a, 20'h00000);
            set_rst(1'b0, 1'b0);
        end
        $display("test dual twin done");
        start(PCT_CFG_BATCH, PCT_CM_INC, 20'h00001, 20'h00001);
        pulse(1'b0, 1);
        check(vals.batch, 20'h00001);
        check(out_a, 1'b1);
        set_rst(1'b0, 1'b1);
        check(out_b, 1'b0);
        check(out_a, 1'b1);
        set_rst(1'b0, 1'b0);
        set_rst(1'b1, 1'b1);
        check(vals.batch, 20'h00000);
        check(out_a, 1'b0);
        set_rst(1'b1, 1'b0);
        $display("test batch done");
        start(PCT_CFG_TACHO, PCT_CM_INC, 20'h00001, 20'h00001);
        @(posedge clock_in);
        hold_key_in <= 1'b1;
        wait_clk(6);
        check(hold_ind, 1'b1);
        pulse(1'b0, 4);
        check(vals.value_a, 20'h00000);
        check(out_a, 1'b0);
        @(posedge clock_in);
        hold_key_in <= 1'b0;
        wait_clk(30);
        check(hold_ind, 1'b0);
        pulse(1'b0, 4);
        check(vals.value_a, 20'h00002);
        check(out_a, 1'b1);
        check(out_b, 1'b1);
        pulse(1'b1, 4);
        check(vals.value_b, 20'h00000);
        $display("test tacho done");
        give_verdict();
    end
    initial begin
        wait_clk(20000);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule : tb_top
